// ==== hdl/cpsirq_pkg.sv ====
// constants for the protection status and interrupt enable block
//
// Behaviour
// - status bit 4 sets on downstream plug event, clears when status is read
// - status bit 3 shows a downstream receiver is currently detected
// - status bit 2 sets when list fetched; engine stalls until list-valid write clears it
// - status bit 1 sets when vector ready; non-repeater stalls until vector-valid write
// - status bit 0 sets on auth success, clears on auth loss or restart
// - enable bit 7 permits interrupt on indirect access completion
// - enable bit 6 permits detect interrupt; waits for lock when select bit set
// - enable bit 5 passes downstream receiver interrupt requests to the host
// - enable bit 4 permits interrupt on vector list ready
// - enable bit 3 permits interrupt on receiver vector ready
// - enable bit 2 permits interrupt on auth failure or loss
// - enable bit 0 globally gates enabled conditions onto the interrupt line
// - global interrupt status flag set whenever any enabled condition is indicated
package cpsirq_pkg;
	// ************************************************************
	// register map: register indices, byte address is four times the index
	// ************************************************************
	localparam logic [7:0]  CPS_IDX_STATUS  = 8'hC4; // auth_status_flags
	localparam logic [7:0]  CPS_IDX_ENABLE  = 8'hC6; // irq_enable_mask
	localparam logic [7:0]  CPS_IDX_IRQSTS  = 8'hC7; // irq_status_reg
	localparam logic [7:0]  CPS_IDX_CTRL    = 8'hC3; // acks and restart
	localparam logic [7:0]  CPS_IDX_CONFIG  = 8'hC2; // auth_config_reg, placement is our own
	localparam logic [11:0] CPS_ADDR_STATUS = {2'b00, CPS_IDX_STATUS, 2'b00};
	localparam logic [11:0] CPS_ADDR_ENABLE = {2'b00, CPS_IDX_ENABLE, 2'b00};
	localparam logic [11:0] CPS_ADDR_IRQSTS = {2'b00, CPS_IDX_IRQSTS, 2'b00};
	localparam logic [11:0] CPS_ADDR_CTRL   = {2'b00, CPS_IDX_CTRL, 2'b00};
	localparam logic [11:0] CPS_ADDR_CONFIG = {2'b00, CPS_IDX_CONFIG, 2'b00};
	localparam logic [7:0] CPS_ENABLE_RESET = 8'h00;
	// ************************************************************
	// field positions
	// ************************************************************
	localparam int CPS_ST_PLUG   = 4;
	localparam int CPS_ST_DETECT = 3;
	localparam int CPS_ST_LIST   = 2;
	localparam int CPS_ST_VECTOR = 1;
	localparam int CPS_ST_AUTH   = 0;
	localparam int CPS_EN_INDIRECT = 7;
	localparam int CPS_EN_FOUND    = 6;
	localparam int CPS_EN_DSREQ    = 5;
	localparam int CPS_EN_LIST     = 4;
	localparam int CPS_EN_VECTOR   = 3;
	localparam int CPS_EN_FAIL     = 2;
	localparam int CPS_EN_PASS     = 1;
	localparam int CPS_EN_GLOBAL   = 0;
	localparam int CPS_CT_LISTACK  = 5;
	localparam int CPS_CT_VECACK   = 4;
	localparam int CPS_CT_RESTART  = 0;
	localparam int CPS_CF_WAITLOCK = 0;
	localparam int CPS_CF_REPEATER = 1;
endpackage : cpsirq_pkg

// ==== hdl/cpsirq_sync.sv ====
// two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ns
`default_nettype none
module cpsirq_sync #(
	parameter int W = 1
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         ce,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;
	// ************************************************************
	// first stage feeds only the second
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= '0;
			q      <= '0;
		end else if (ce) begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule : cpsirq_sync
`default_nettype wire

// ==== hdl/cpsirq_edge.sv ====
// rising edge detector on synchronised levels
`timescale 1ns/1ns
`default_nettype none
module cpsirq_edge #(
	parameter int W = 1
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         ce,
	input  wire logic [W-1:0] lvl,
	output logic      [W-1:0] rise
);
	logic [W-1:0] prev_q;
	// pulse only for one enabled cycle
	assign rise = lvl & ~prev_q & {W{ce}};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_q <= '0;
		end else if (ce) begin
			prev_q <= lvl;
		end
	end
endmodule : cpsirq_edge
`default_nettype wire

// ==== hdl/cpsirq_top.sv ====
// status flags, interrupt enable mask and apb slave of the protection block
//
// Chosen here: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module cpsirq_top
	import cpsirq_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        downstream_plug_event,
	input  wire logic        receiver_detect,
	input  wire logic        receiver_lock,
	input  wire logic        downstream_irq_n,
	input  wire logic        indirect_done,
	input  wire logic        list_fetched,
	input  wire logic        vector_fetched,
	input  wire logic        auth_pass,
	input  wire logic        auth_fail,
	output logic             engine_stall,
	output logic             auth_restart,
	output logic             irq_out
);
	// ************************************************************
	// pin synchronisation
	// ************************************************************
	logic [9:0] pins_s;
	logic [9:0] pins_r;
	cpsirq_sync #(.W(10)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.d       ({downstream_plug_event, receiver_detect, receiver_lock,
		           ~downstream_irq_n, indirect_done, list_fetched,
		           vector_fetched, auth_pass, auth_fail, 1'b0}),
		.q       (pins_s)
	);
	cpsirq_edge #(.W(10)) u_edge (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.lvl     (pins_s),
		.rise    (pins_r)
	);
	wire plug_ev   = pins_r[9];
	wire det_lvl   = pins_s[8];
	wire lock_lvl  = pins_s[7];
	wire dsreq_lvl = pins_s[6];
	wire ind_ev    = pins_r[5];
	wire list_ev   = pins_r[4];
	wire vec_ev    = pins_r[3];
	wire pass_ev   = pins_r[2];
	wire fail_ev   = pins_r[1];

	// ************************************************************
	// apb decode; zero wait states, every access ends at first access edge
	// ************************************************************
	wire acc      = psel & penable & ce;
	wire wr       = acc & pwrite;
	wire rd       = acc & ~pwrite;
	wire hit_sts  = (paddr == CPS_ADDR_STATUS);
	wire hit_en   = (paddr == CPS_ADDR_ENABLE);
	wire hit_is   = (paddr == CPS_ADDR_IRQSTS);
	wire hit_ct   = (paddr == CPS_ADDR_CTRL);
	wire hit_cf   = (paddr == CPS_ADDR_CONFIG);
	wire mapped   = hit_sts | hit_en | hit_is | hit_ct | hit_cf;
	wire rd_sts   = rd & hit_sts;
	wire wr_en    = wr & hit_en;
	wire wr_ct    = wr & hit_ct;
	wire wr_cf    = wr & hit_cf;
	wire list_ack = wr_ct & pwdata[CPS_CT_LISTACK];
	wire vec_ack  = wr_ct & pwdata[CPS_CT_VECACK];
	wire restart  = wr_ct & pwdata[CPS_CT_RESTART];

	// ************************************************************
	// state registers
	// ************************************************************
	logic [7:0] enable_q;
	logic [1:0] config_q;
	logic       plug_q, plug_d;
	logic       list_q, list_d;
	logic       vec_q, vec_d;
	logic       auth_q, auth_d;
	logic       found_q;
	logic [7:0] irqsts_q, irqsts_d;

	// sticky flags: a set in the clearing cycle wins
	assign plug_d = plug_ev | (plug_q & ~rd_sts);
	assign list_d = list_ev | (list_q & ~list_ack);
	assign vec_d  = vec_ev | (vec_q & ~vec_ack);
	assign auth_d = pass_ev | (auth_q & ~fail_ev & ~restart);

	// detect condition, optionally held until the link locks
	wire det_cond = det_lvl & (lock_lvl | ~config_q[CPS_CF_WAITLOCK]);
	wire found_ev = det_cond & ~found_q;
	wire loss_ev  = fail_ev;                                          // covers loss too

	// ************************************************************
	// interrupt sources gated by the enable mask
	// ************************************************************
	logic [7:1] cause;
	always_comb begin
		cause                  = '0;
		cause[CPS_EN_INDIRECT] = ind_ev;
		cause[CPS_EN_FOUND]    = found_ev;
		cause[CPS_EN_DSREQ]    = dsreq_lvl;
		cause[CPS_EN_LIST]     = list_ev;
		cause[CPS_EN_VECTOR]   = vec_ev;
		cause[CPS_EN_FAIL]     = loss_ev;
		cause[CPS_EN_PASS]     = pass_ev;
	end
	wire [7:1] gated  = cause & enable_q[7:1];
	wire [7:1] pend_d = gated | (irqsts_q[7:1] & ~{7{rd & hit_is}});
	// global flag follows any enabled pending condition
	assign irqsts_d = {pend_d, |pend_d};

	// ************************************************************
	// register updates
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_q <= CPS_ENABLE_RESET;
			config_q <= '0;
			plug_q   <= 1'b0;
			list_q   <= 1'b0;
			vec_q    <= 1'b0;
			auth_q   <= 1'b0;
			found_q  <= 1'b0;
			irqsts_q <= '0;
		end else if (ce) begin
			if (wr_en) enable_q <= pwdata[7:0];
			if (wr_cf) config_q <= pwdata[1:0];
			plug_q   <= plug_d;
			list_q   <= list_d;
			vec_q    <= vec_d;
			auth_q   <= auth_d;
			found_q  <= det_cond;
			irqsts_q <= irqsts_d;
		end
	end

	// ************************************************************
	// read mux and outputs, all registered
	// ************************************************************
	wire [7:0] sts_val = {3'h0, plug_q, det_lvl, list_q, vec_q, auth_q};
	wire [7:0] rd_val  = hit_sts ? sts_val :
	                     hit_en  ? enable_q :
	                     hit_is  ? irqsts_q :
	                     hit_cf  ? {6'h00, config_q} : 8'h00;
	// the engine holds while a list or a non-repeater vector awaits the host
	wire stall_d = list_d | (vec_d & ~config_q[CPS_CF_REPEATER]);
	wire irq_d   = enable_q[CPS_EN_GLOBAL] & irqsts_d[0];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata       <= 32'h0000_0000;
			pready       <= 1'b0;
			pslverr      <= 1'b0;
			engine_stall <= 1'b0;
			auth_restart <= 1'b0;
			irq_out      <= 1'b0;
		end else if (ce) begin
			prdata       <= {24'h000000, rd_val};
			pready       <= 1'b1;
			pslverr      <= psel & ~mapped;
			engine_stall <= stall_d;
			auth_restart <= restart;
			irq_out      <= irq_d;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	AST_PLUG_CLR: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && rd_sts && !plug_ev) |=> !plug_q)
		else $error("plug flag not cleared by status read");
	AST_DET_LIVE: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && psel && !penable && hit_sts) |=> prdata[CPS_ST_DETECT] == $past(det_lvl))
		else $error("detect bit not live");
	AST_LIST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && list_q && !list_ack) |=> (list_q && engine_stall))
		else $error("list flag dropped without ack");
	AST_VEC_CLR: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && vec_ack && !vec_ev) |=> !vec_q)
		else $error("vector flag not cleared by ack");
	AST_AUTH_LOSS: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && (restart || fail_ev) && !pass_ev) |=> !auth_q)
		else $error("auth flag survived restart or loss");
	AST_WAIT_LOCK: assert property (@(posedge pclk) disable iff (!presetn)
		(config_q[CPS_CF_WAITLOCK] && !lock_lvl) |-> !cause[CPS_EN_FOUND])
		else $error("detect interrupt before lock");
	AST_MASKED: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && !enable_q[CPS_EN_LIST] && !irqsts_q[CPS_EN_LIST]) |=>
		!irqsts_q[CPS_EN_LIST])
		else $error("masked list interrupt pended");
	AST_GLOBAL: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && !enable_q[CPS_EN_GLOBAL]) |=> !irq_out)
		else $error("interrupt raised with global gate off");
	AST_ANY: assert property (@(posedge pclk) disable iff (!presetn)
		ce |=> irqsts_q[0] == (|irqsts_q[7:1]))
		else $error("global flag disagrees with pending bits");
	COV_PLUG: cover property (@(posedge pclk) disable iff (!presetn) plug_q ##1 !plug_q);
	COV_IRQ: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq_out));
	COV_STALL: cover property (@(posedge pclk) disable iff (!presetn) $fell(engine_stall));
endmodule : cpsirq_top
`default_nettype wire

// ==== testbench/cpsirq_host_model.sv ====
// host controller model: apb master that reads status and sets enables
`timescale 1ns/1ns
`default_nettype none
module cpsirq_host_model
	import cpsirq_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        pready,
	input  wire logic        pslverr,
	input  wire logic [31:0] prdata,
	output logic             psel = 1'b0,
	output logic             penable = 1'b0,
	output logic             pwrite = 1'b0,
	output logic      [11:0] paddr = 12'h000,
	output logic      [31:0] pwdata = 32'h00000000,
	output logic             hang = 1'b0
);
	// one transfer; request held until pready is seen high at an edge, for at most 20 edges, else hang is raised
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) hang <= 1'b1;
		rd = prdata;
		err = pslverr;
		// released lines show the inverse so stale values never pass
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~wd;
	endtask : xfer

	// list ack only after the list has been looked at
	task ack_list();
		logic [31:0] d;
		logic        e;
		xfer(1'b0, CPS_ADDR_STATUS, 32'h0, d, e);
		if (d[CPS_ST_LIST]) xfer(1'b1, CPS_ADDR_CTRL, 32'h1 << CPS_CT_LISTACK, d, e);
	endtask : ack_list
endmodule : cpsirq_host_model
`default_nettype wire

// ==== testbench/cpsirq_top_bench.sv ====
// self-checking bench for the status and interrupt enable block
`timescale 1ns/1ns
`default_nettype none
module cpsirq_top_bench;
	import cpsirq_pkg::*;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        lock = 1'b0;
	logic [7:0]  cause = 8'h00;
	logic        psel, penable, pwrite, pready, pslverr, hang;
	logic        engine_stall, irq_out;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, d;
	logic        e;
	int          n_mismatch = 0;
	int          check_count = 0;

	initial forever #10 pclk = ~pclk;

	cpsirq_host_model cpsirq_host_model_i (.pclk(pclk), .pready(pready),
		.pslverr(pslverr), .prdata(prdata), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .hang(hang));

	// cause bit b drives the source of irq status bit b; bit 0 is the plug event
	cpsirq_top cpsirq_top_i (.pclk(pclk), .presetn(presetn), .ce(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.downstream_plug_event(cause[0]), .receiver_detect(cause[6]),
		.receiver_lock(lock), .downstream_irq_n(~cause[5]),
		.indirect_done(cause[7]), .list_fetched(cause[4]),
		.vector_fetched(cause[3]), .auth_pass(cause[1]), .auth_fail(cause[2]),
		.engine_stall(engine_stall), .auth_restart(), .irq_out(irq_out));

	task wrap_up();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up

	task chk(string nm, logic [31:0] ex, logic [31:0] got);
		check_count++;
		if (got !== ex) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk

	task wr(logic [11:0] a, logic [31:0] v);
		cpsirq_host_model_i.xfer(1'b1, a, v, d, e);
	endtask : wr

	task rdc(string nm, logic [11:0] a, logic [31:0] ex);
		cpsirq_host_model_i.xfer(1'b0, a, 32'h0, d, e);
		chk(nm, ex, d);
	endtask : rdc

	// pulse held long enough to pass the synchroniser, then settle
	task pulse(int b);
		@(posedge pclk);
		cause[b] <= 1'b1;
		repeat (3) @(posedge pclk);
		cause[b] <= 1'b0;
		repeat (6) @(posedge pclk);
	endtask : pulse

	// a hung transfer ends the run at once
	always @(posedge hang) begin
		n_mismatch++;
		wrap_up();
	end

	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rdc("enable reset", CPS_ADDR_ENABLE, 32'h00);
		wr(CPS_ADDR_ENABLE, 32'hFF);
		rdc("enable rw", CPS_ADDR_ENABLE, 32'hFF);
		cpsirq_host_model_i.xfer(1'b0, 12'h010, 32'h0, d, e);
		chk("unmapped data", 32'h0, d);
		chk("unmapped err", 32'h1, 32'(e));
		pulse(0);
		rdc("plug set", CPS_ADDR_STATUS, 32'h10);
		rdc("plug clear", CPS_ADDR_STATUS, 32'h00);
		// every cause in turn, each read clearing its pending bit
		for (int b = 7; b >= 1; b--) begin
			pulse(b);
			chk("irq line", 32'h1, 32'(irq_out));
			rdc("irq status", CPS_ADDR_IRQSTS, (32'h1 << b) | 32'h1);
			rdc("irq cleared", CPS_ADDR_IRQSTS, 32'h0);
		end
		rdc("status flags", CPS_ADDR_STATUS, 32'h07);
		chk("stall", 32'h1, 32'(engine_stall));
		cpsirq_host_model_i.ack_list();
		rdc("list acked", CPS_ADDR_STATUS, 32'h03);
		chk("stall vector", 32'h1, 32'(engine_stall));
		wr(CPS_ADDR_CTRL, 32'h1 << CPS_CT_VECACK);
		rdc("vector acked", CPS_ADDR_STATUS, 32'h01);
		chk("no stall", 32'h0, 32'(engine_stall));
		// detect interrupt held off until lock
		wr(CPS_ADDR_CONFIG, 32'h1);
		cause[6] <= 1'b1;
		repeat (8) @(posedge pclk);
		chk("detect no lock", 32'h0, 32'(irq_out));
		rdc("detect level", CPS_ADDR_STATUS, 32'h09);
		lock <= 1'b1;
		repeat (8) @(posedge pclk);
		chk("detect lock", 32'h1, 32'(irq_out));
		rdc("detect irq", CPS_ADDR_IRQSTS, 32'h41);
		cause[6] <= 1'b0;
		// global gate off keeps the line low while pending stays
		wr(CPS_ADDR_ENABLE, 32'hFE);
		pulse(7);
		chk("gate off", 32'h0, 32'(irq_out));
		wr(CPS_ADDR_ENABLE, 32'hFF);
		repeat (3) @(posedge pclk);
		chk("gate on", 32'h1, 32'(irq_out));
		rdc("gated irq", CPS_ADDR_IRQSTS, 32'h81);
		wr(CPS_ADDR_CTRL, 32'h1 << CPS_CT_RESTART);
		rdc("restart", CPS_ADDR_STATUS, 32'h00);
		wrap_up();
	end
endmodule : cpsirq_top_bench
`default_nettype wire
